// >>> logic/burst_sram_pkg.sv
// Shared constants and types for the burst SRAM control block.
// Assumes a single clock domain and a synchronous active-high reset.
package burst_sram_pkg;

  // ---------------------------------------------------------------------
  // Organisation
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W     = 18;
  localparam int unsigned LANES      = 4;
  localparam int unsigned LANE_W     = 9;
  localparam int unsigned DATA_W     = LANES * LANE_W;
  localparam int unsigned WORDS      = 1 << ADDR_W;
  localparam int unsigned FIFO_DEPTH = 16;
  // 1: four-lane wide organisation; 0: two-lane narrow organisation
  localparam logic        WIDE_ORG   = 1'b1;
  localparam logic [LANES-1:0] LANE_ALL  = 4'hf;
  localparam logic [LANES-1:0] LANE_LOW2 = 4'h3;

  // ---------------------------------------------------------------------
  // Burst counter
  // ---------------------------------------------------------------------
  localparam int unsigned CNT_W    = 2;
  localparam logic [1:0]  CNT_RST  = 2'h0;
  localparam logic [1:0]  CNT_STEP = 2'h1;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_STANDBY,
    PWR_ACTIVE,
    PWR_SLEEP
  } power_e;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_e;

  // One buffered write: word address, lane enables, data
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lanes;
    logic [DATA_W-1:0] data;
  } wr_entry_s;

  localparam int unsigned ENTRY_W = $bits(wr_entry_s);

  // Whole state of the control core
  typedef struct packed {
    logic                  live;
    logic [ADDR_W-1:2]     hi;
    logic [CNT_W-1:0]      start;
    logic [CNT_W-1:0]      count;
    logic [DATA_W-1:0]     dout;
    logic                  drive;
    power_e                power;
    logic                  dropped;
  } core_s;

  localparam core_s CORE_RST = '0;

endpackage : burst_sram_pkg

// >>> logic/burst_sram_sync_control.sv
// Burst SRAM synchronous control core plus its write buffer FIFO.
// Assumes pin inputs are synchronous to clk; output_drive_n and
// sleep_request gate the data drive enable without the clock.
//
// Contract
// (RQ1) Deselect: enable off, cache strobe low; or unselected with a strobe.
// (RQ2) Selected, proc strobe low: begin read, write controls ignored.
// (RQ3) Cache strobe begin while selected: write if asked, else read.
// (RQ4) Continue, step low, no write: advance counter, read next word.
// (RQ5) Continue, step low, write: advance counter, write next word.
// (RQ6) Continue, step high, no write: hold counter, read current again.
// (RQ7) Step high with write requested: hold address, write data there.
// (RQ8) Global write writes all lanes; gate high or all selects high reads.
// (RQ9) With gate low exactly the lanes whose select is low are written.
// (RQ10) Narrow organisation uses only first two lane selects.
// (RQ11) Read data driven only while output_drive_n low during reads.
// (RQ12) Sleep request overrides all, data high-impedance, sleep state.
// (RQ13) Order select high: low bits are start XOR count.
// (RQ14) Order select low: low bits are start plus count modulo four.
// (RQ15) Advance after fourth word wraps to the starting address.
// (RQ16) Deselected means standby power and no data drive.
// (RQ17) Controller keeps order select static and waits configuration time.
// (RQ18) Controller waits recovery after sleep and resumes deselected.
// (RQ19) Only two low address bits step; upper bits held from capture.
// (RQ20) Read word stands in the cycle right after its address is captured.
// (RQ21) Each lane select governs one nine-bit lane in lane order.
`timescale 1ns/1ps

// -----------------------------------------------------------------------
// Write buffer
// -----------------------------------------------------------------------
module word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW:0] ONE_CNT  = (PW + 1)'(1);
  localparam logic [PW-1:0] ONE_PTR = PW'(1);

  typedef struct packed {
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0]   count;
    logic          full;
  } fifo_state_s;

  fifo_state_s       st_ff;
  fifo_state_s       nxt_st;
  logic [WIDTH-1:0]  store [DEPTH];
  logic              push;
  logic              pop;

  // Flags come from the registered state, so the source sees no comb path
  assign in_ready  = ~st_ff.full;
  assign out_valid = (st_ff.count != '0);
  assign out_data  = store[st_ff.rptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and occupancy update
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.wptr = st_ff.wptr + ONE_PTR;
    end
    if (pop) begin
      nxt_st.rptr = st_ff.rptr + ONE_PTR;
    end
    case ({push, pop})
      2'b10:   nxt_st.count = st_ff.count + ONE_CNT;
      2'b01:   nxt_st.count = st_ff.count - ONE_CNT;
      default: nxt_st.count = st_ff.count;
    endcase
    nxt_st.full = (nxt_st.count == FULL_CNT);
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Storage, no reset needed: only read when occupied
  always_ff @(posedge clk) begin
    if (push) begin
      store[st_ff.wptr] <= in_data;
    end
  end

endmodule : word_fifo

// -----------------------------------------------------------------------
// Control core
// -----------------------------------------------------------------------
module burst_sram_sync_control (
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              chip_enable_n,
  input  wire logic                              select_active_high,
  input  wire logic                              select_active_low,
  input  wire logic                              proc_addr_strobe,
  input  wire logic                              cache_addr_strobe,
  input  wire logic                              burst_step_n,
  input  wire logic                              global_write_n,
  input  wire logic                              byte_write_gate,
  input  wire logic [burst_sram_pkg::LANES-1:0]  lane_select_n,
  input  wire logic                              output_drive_n,
  input  wire logic                              sleep_request,
  input  wire logic                              burst_order_select,
  input  wire logic [burst_sram_pkg::ADDR_W-1:0] addr,
  input  wire logic [burst_sram_pkg::DATA_W-1:0] data_in,
  output logic      [burst_sram_pkg::DATA_W-1:0] data_out,
  output logic                                   data_oe,
  output logic      [1:0]                        power_state,
  output logic                                   write_ready,
  output logic                                   write_dropped
);

  // ---------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------

  // Lane enables from the write controls, all active low at the pins
  function automatic logic [burst_sram_pkg::LANES-1:0] lane_enables(
    input logic                             gw_n,
    input logic                             gate_n,
    input logic [burst_sram_pkg::LANES-1:0] sel_n
  );
    logic [burst_sram_pkg::LANES-1:0] usable;
    usable = burst_sram_pkg::WIDE_ORG ? burst_sram_pkg::LANE_ALL
                                      : burst_sram_pkg::LANE_LOW2; // [RQ10]
    if (!gw_n) begin
      lane_enables = usable;                                       // [RQ8]
    end else if (gate_n) begin
      lane_enables = '0;                                           // [RQ8]
    end else begin
      lane_enables = ~sel_n & usable;                              // [RQ9]
    end
  endfunction : lane_enables

  // Low address bits for a given start and burst count
  function automatic logic [1:0] burst_low(
    input logic [1:0] start,
    input logic [1:0] count,
    input logic       interleaved
  );
    if (interleaved) begin
      burst_low = start ^ count;                                   // [RQ13]
    end else begin
      burst_low = start + count;                                   // [RQ14]
    end
  endfunction : burst_low

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  burst_sram_pkg::core_s                   st_ff;
  burst_sram_pkg::core_s                   nxt_st;
  burst_sram_pkg::op_e                     op;
  burst_sram_pkg::wr_entry_s               push_entry;
  burst_sram_pkg::wr_entry_s               drain_entry;
  logic [burst_sram_pkg::ADDR_W-1:0]       cur_addr;
  logic [burst_sram_pkg::DATA_W-1:0]       rd_word;
  logic [burst_sram_pkg::LANES-1:0]        wr_lanes;
  logic                                    wr_req;
  logic                                    selected;
  logic                                    deselect;
  logic                                    continue_cyc;
  logic                                    buf_ready;
  logic                                    drain_valid;
  logic                                    drain_ready;
  logic                                    drain_fire;

  // ---------------------------------------------------------------------
  // Cycle classification
  // ---------------------------------------------------------------------
  assign wr_lanes = lane_enables(global_write_n, byte_write_gate,
                                 lane_select_n);
  assign wr_req   = |wr_lanes;
  assign selected = ~chip_enable_n & select_active_high & ~select_active_low;
  // Both deselect cases
  assign deselect = (chip_enable_n & ~cache_addr_strobe) |
                    (~chip_enable_n & ~selected &
                     (~proc_addr_strobe | ~cache_addr_strobe));    // [RQ1]
  assign continue_cyc = cache_addr_strobe &
                        (proc_addr_strobe | chip_enable_n);

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.dropped = 1'b0;
    nxt_st.drive   = 1'b0;
    op             = burst_sram_pkg::OP_IDLE;
    cur_addr       = {st_ff.hi,
                      burst_low(st_ff.start, st_ff.count, burst_order_select)};
    if (sleep_request) begin
      nxt_st.live  = 1'b0;
      nxt_st.power = burst_sram_pkg::PWR_SLEEP;                    // [RQ12]
    end else if (deselect) begin
      nxt_st.live  = 1'b0;
      nxt_st.power = burst_sram_pkg::PWR_STANDBY;                  // [RQ16]
    end else if (selected && !proc_addr_strobe) begin
      // Processor strobe: read regardless of write controls
      nxt_st.live  = 1'b1;
      nxt_st.hi    = addr[burst_sram_pkg::ADDR_W-1:2];
      nxt_st.start = addr[1:0];
      nxt_st.count = burst_sram_pkg::CNT_RST;
      cur_addr     = addr;
      op           = burst_sram_pkg::OP_READ;                      // [RQ2]
    end else if (selected && !cache_addr_strobe) begin
      nxt_st.live  = 1'b1;
      nxt_st.hi    = addr[burst_sram_pkg::ADDR_W-1:2];
      nxt_st.start = addr[1:0];
      nxt_st.count = burst_sram_pkg::CNT_RST;
      cur_addr     = addr;
      op           = wr_req ? burst_sram_pkg::OP_WRITE
                            : burst_sram_pkg::OP_READ;             // [RQ3]
    end else if (continue_cyc && st_ff.live) begin
      if (!burst_step_n) begin
        // Two-bit count wraps after the fourth word
        nxt_st.count = st_ff.count + burst_sram_pkg::CNT_STEP;     // [RQ15]
      end
      // Upper bits stay as captured; only the low pair moves
      cur_addr = {st_ff.hi,
                  burst_low(st_ff.start, nxt_st.count,
                            burst_order_select)};                  // [RQ19]
      // Step low: advance; step high: same address again
      op = wr_req ? burst_sram_pkg::OP_WRITE                       // [RQ5] [RQ7]
                  : burst_sram_pkg::OP_READ;                       // [RQ4] [RQ6]
    end else begin
      // Continue strobes with no burst under way stay idle
      nxt_st.power = burst_sram_pkg::PWR_STANDBY;
    end
    if (op != burst_sram_pkg::OP_IDLE) begin
      nxt_st.power = burst_sram_pkg::PWR_ACTIVE;
    end
    if (op == burst_sram_pkg::OP_READ) begin
      nxt_st.dout  = rd_word;                                      // [RQ20]
      nxt_st.drive = 1'b1;
    end
    if (op == burst_sram_pkg::OP_WRITE && !buf_ready) begin
      nxt_st.dropped = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= burst_sram_pkg::CORE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------
  // Write buffer: writes queue, array drains on non-read cycles
  // ---------------------------------------------------------------------
  assign push_entry.addr  = cur_addr;
  assign push_entry.lanes = wr_lanes;
  assign push_entry.data  = data_in;
  // Single-port array: a read cycle stalls the drain. Limitation: a read
  // of a word still queued returns the older contents.
  assign drain_ready = (op != burst_sram_pkg::OP_READ);
  assign drain_fire  = drain_valid & drain_ready;

  word_fifo #(
    .WIDTH (burst_sram_pkg::ENTRY_W),
    .DEPTH (burst_sram_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (op == burst_sram_pkg::OP_WRITE),
    .in_ready  (buf_ready),
    .in_data   (push_entry),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_entry)
  );

  // ---------------------------------------------------------------------
  // Array, one nine-bit memory per lane
  // ---------------------------------------------------------------------
  for (genvar g = 0; g < burst_sram_pkg::LANES; g++) begin : g_lane
    logic [burst_sram_pkg::LANE_W-1:0] lane_mem [burst_sram_pkg::WORDS];

    always_ff @(posedge clk) begin
      if (drain_fire && drain_entry.lanes[g]) begin
        lane_mem[drain_entry.addr] <=
          drain_entry.data[g*burst_sram_pkg::LANE_W +:
                           burst_sram_pkg::LANE_W];                // [RQ21]
      end
    end

    assign rd_word[g*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
      lane_mem[cur_addr];
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign data_out      = st_ff.dout;
  // Unclocked gating: drive enable follows output_drive_n and sleep
  assign data_oe       = st_ff.drive & ~output_drive_n &
                         ~sleep_request;                           // [RQ11] [RQ12]
  assign power_state   = st_ff.power;
  assign write_ready   = buf_ready;
  assign write_dropped = st_ff.dropped;

endmodule : burst_sram_sync_control

// >>> tb/burst_sram_props.sv
// Port checker for the burst SRAM control core.
// Assumes it is bound onto burst_sram_sync_control; one clock.
`timescale 1ns/1ps
module burst_sram_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       chip_enable_n,
  input wire logic       select_active_high,
  input wire logic       select_active_low,
  input wire logic       proc_addr_strobe,
  input wire logic       cache_addr_strobe,
  input wire logic       global_write_n,
  input wire logic       byte_write_gate,
  input wire logic       output_drive_n,
  input wire logic       sleep_request,
  input wire logic       data_oe,
  input wire logic [1:0] power_state,
  input wire logic       write_ready,
  input wire logic       write_dropped
);
  // ---------------------------------------------------------------------
  // Clocked decode checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Both selects in their active sense
  wire sel = !chip_enable_n && select_active_high && !select_active_low;
  property p_desel_ce;
    !sleep_request && chip_enable_n && !cache_addr_strobe
      |=> power_state == 2'h0 && !data_oe;
  endproperty
  a_desel_ce: assert property (p_desel_ce)
    else $error("chip enable deselect missed");
  property p_desel_cs;
    !sleep_request && !chip_enable_n &&
      (!select_active_high || select_active_low) &&
      (!proc_addr_strobe || !cache_addr_strobe)
      |=> power_state == 2'h0 && !data_oe;
  endproperty
  a_desel_cs: assert property (p_desel_cs)
    else $error("chip select deselect missed");
  property p_rd_begin;
    !sleep_request && sel && !proc_addr_strobe
      |=> power_state == 2'h1 && (data_oe || output_drive_n || sleep_request);
  endproperty
  a_rd_begin: assert property (p_rd_begin)
    else $error("read begin not driven");
  property p_wr_begin;
    !sleep_request && sel && proc_addr_strobe && !cache_addr_strobe &&
      !global_write_n |=> power_state == 2'h1 && !data_oe;
  endproperty
  a_wr_begin: assert property (p_wr_begin)
    else $error("write begin drove data");
  property p_oe_gate;
    data_oe |-> !output_drive_n;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("drive with output enable high");
  property p_sleep_oe;
    sleep_request |-> !data_oe;
  endproperty
  a_sleep_oe: assert property (p_sleep_oe)
    else $error("drive during sleep");
  property p_sleep;
    sleep_request |=> power_state == 2'h2;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep state missed");
  // A lost write is only legal while the buffer was full
  property p_drop;
    write_dropped |-> $past(!write_ready);
  endproperty
  a_drop: assert property (p_drop)
    else $error("write lost with room left");
  c_read: cover property (sel && !proc_addr_strobe && !output_drive_n);
  c_sleep: cover property (sleep_request [*3]);
  c_lane: cover property (sel && proc_addr_strobe && !cache_addr_strobe &&
                          global_write_n && !byte_write_gate);
endmodule : burst_sram_props

// >>> tb/host_model.sv
// Controller-side model that drives every SRAM bus pin.
// Assumes the bench calls its tasks; pins move on falling clk.
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk,
  output logic             chip_enable_n,
  output logic             select_active_high,
  output logic             select_active_low,
  output logic             proc_addr_strobe,
  output logic             cache_addr_strobe,
  output logic             burst_step_n,
  output logic             global_write_n,
  output logic             byte_write_gate,
  output logic [3:0]       lane_select_n,
  output logic             output_drive_n,
  output logic             sleep_request,
  output logic             burst_order_select,
  output logic [17:0]      addr,
  output logic [35:0]      data_in
);
  // ---------------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------------
  logic [11:0] ctl;
  assign {chip_enable_n, select_active_high, select_active_low,
          proc_addr_strobe, cache_addr_strobe, burst_step_n,
          global_write_n, byte_write_gate, lane_select_n} = ctl;
  // Power up deselected, interleaved order
  initial begin
    ctl = 12'hd7f;
    addr = 18'h0;
    data_in = 36'h0;
    output_drive_n = 1'b0;
    sleep_request = 1'b0;
    burst_order_select = 1'b1;
  end
  // One bus cycle; held through the following rising edge
  task automatic put(input logic [11:0] c, input logic [17:0] a,
                     input logic [35:0] d);
    @(negedge clk);
    ctl = c;
    addr = a;
    data_in = d;
  endtask : put
  // Unused lines flip so stale values never pass as data
  task automatic rd(input logic [17:0] a, input logic gw);
    put({4'h4, 2'h3, gw, 1'b1, 4'hf}, a, ~data_in);
  endtask : rd
  task automatic wr(input logic [17:0] a, input logic gw, input logic bw,
                    input logic [3:0] l, input logic [35:0] d);
    put({4'h5, 2'h1, gw, bw, l}, a, d);
  endtask : wr
  task automatic nx(input logic st, input logic gw, input logic bw,
                    input logic [3:0] l, input logic [35:0] d);
    put({4'hd, 1'b1, st, gw, bw, l}, ~addr, d);
  endtask : nx
  // Unselected chip with an address strobe low; r, s each 0 to 2
  task automatic cs_off(input logic [1:0] r, input logic [1:0] s);
    put({1'b0, r[1], |r, s, 3'h7, 4'hf}, ~addr, ~data_in);
  endtask : cs_off
  // Unclocked pins, moved by the caller off the clock edge
  task automatic pins(input logic oe_n, input logic zz);
    output_drive_n = oe_n;
    sleep_request = zz;
  endtask : pins
  task automatic idle(input int n);
    repeat (n) put(12'hd7f, ~addr, ~data_in);
  endtask : idle
  // Order changes only while idle, then 50 ns settle
  task automatic order(input logic v);
    idle(1);
    burst_order_select = v;
    idle(13);
  endtask : order
endmodule : host_model

// >>> tb/test_burst_sram_sync_control.sv
// Self-checking bench for burst_sram_sync_control.
// Assumes host_model drives the pins and a shadow array predicts reads.
`timescale 1ns/1ps
module test_burst_sram_sync_control;
  logic clk, rst, chip_enable_n, select_active_high, select_active_low;
  logic proc_addr_strobe, cache_addr_strobe, burst_step_n, global_write_n;
  logic byte_write_gate, output_drive_n, sleep_request, burst_order_select;
  logic [3:0]  lane_select_n;
  logic [17:0] addr, base;
  logic [35:0] data_in, data_out, d;
  logic        data_oe, write_ready, write_dropped;
  logic [1:0]  power_state;
  logic [35:0] mem [int];
  logic [35:0] exp_q [$];
  int          err_count = 0;
  int          compares = 0;
  host_model host_u (.clk, .chip_enable_n, .select_active_high,
    .select_active_low, .proc_addr_strobe, .cache_addr_strobe,
    .burst_step_n, .global_write_n, .byte_write_gate, .lane_select_n,
    .output_drive_n, .sleep_request, .burst_order_select, .addr, .data_in);
  burst_sram_sync_control dut_u (.clk, .rst, .chip_enable_n,
    .select_active_high, .select_active_low, .proc_addr_strobe,
    .cache_addr_strobe, .burst_step_n, .global_write_n, .byte_write_gate,
    .lane_select_n, .output_drive_n, .sleep_request, .burst_order_select,
    .addr, .data_in, .data_out, .data_oe, .power_state, .write_ready,
    .write_dropped);
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  function automatic logic [35:0] rnd();
    return 36'({$urandom, $urandom});
  endfunction : rnd
  function automatic logic [1:0] nxt(logic [1:0] s, int k, logic ilv);
    return ilv ? s ^ k[1:0] : s + k[1:0];
  endfunction : nxt
  task automatic rd_exp(input logic [17:0] a, input logic gw);
    host_u.rd(a, gw);
    if (!output_drive_n) exp_q.push_back(mem[a]);
  endtask : rd_exp
  // Full burst of four, wrap plus one, then a suspended reread
  task automatic rd_burst(input logic [17:0] a, input logic ilv);
    rd_exp(a, 1'b1);
    for (int k = 1; k <= 5; k++) begin
      host_u.nx(1'b0, 1'b1, 1'b1, 4'hf, rnd());
      exp_q.push_back(mem[{a[17:2], nxt(a[1:0], k, ilv)}]);
    end
    host_u.nx(1'b1, 1'b1, 1'b1, 4'hf, rnd());
    exp_q.push_back(mem[{a[17:2], nxt(a[1:0], 5, ilv)}]);
  endtask : rd_burst
  // Global write begin, lane-gated steps, suspended overwrite
  task automatic wr_burst(input logic [17:0] a, input logic ilv);
    d = rnd();
    host_u.wr(a, 1'b0, 1'b1, 4'hf, d);
    mem[a] = d;
    for (int k = 1; k <= 3; k++) begin
      d = rnd();
      host_u.nx(1'b0, 1'b1, 1'b0, 4'h0, d);
      mem[{a[17:2], nxt(a[1:0], k, ilv)}] = d;
    end
    d = rnd();
    host_u.nx(1'b1, 1'b0, 1'b1, 4'hf, d);
    mem[{a[17:2], nxt(a[1:0], 3, ilv)}] = d;
    host_u.idle(4);
  endtask : wr_burst
  // Watcher: each driven read word against the oldest note
  always @(posedge clk) begin
    if (!rst && data_oe === 1'b1) begin
      if (exp_q.size() == 0) chk("spare", 36'h1, 36'h0);
      else chk("data", data_out, exp_q.pop_front());
    end
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  initial begin
    void'($urandom(55));
    rst = 1'b1;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("power", 36'(power_state), 36'h0);
    chk("ready", 36'(write_ready), 36'h1);
    chk("oe", 36'(data_oe), 36'h0);
    $display("test reset done");
    base = 18'($urandom);
    wr_burst(base, 1'b1);
    rd_burst(base ^ 18'h2, 1'b1);
    host_u.order(1'b0);
    wr_burst(base + 18'h4, 1'b0);
    rd_burst((base + 18'h4) ^ 18'h3, 1'b0);
    $display("test bursts done");
    host_u.wr(base, 1'b1, 1'b1, 4'h0, rnd());
    exp_q.push_back(mem[base]);
    for (int l = 0; l < 16; l++) begin
      d = rnd();
      host_u.wr(base, 1'b1, 1'b0, 4'(l), d);
      if (l == 15) exp_q.push_back(mem[base]);
      else mem[base] = mrg(mem[base], d, 4'(l));
      host_u.idle(3);
      rd_exp(base, 1'b1);
    end
    rd_exp(base, 1'b0);
    host_u.idle(3);
    rd_exp(base, 1'b1);
    $display("test lanes done");
    // Chip-select deselect must end the burst: no continue read after it
    for (int r = 0; r < 6; r++) begin
      rd_exp(base, 1'b1);
      host_u.cs_off(2'($urandom % 3), 2'($urandom % 3));
      host_u.nx(1'b0, 1'b1, 1'b1, 4'hf, rnd());
      host_u.idle(1);
      chk("desel", 36'(power_state), 36'h0);
    end
    $display("test selects done");
    host_u.idle(1);
    host_u.pins(1'b1, 1'b0);
    rd_exp(base, 1'b1);
    @(posedge clk);
    #1 chk("oe_off", 36'(data_oe), 36'h0);
    host_u.idle(2);
    host_u.pins(1'b0, 1'b1);
    host_u.idle(25);
    chk("sleep", 36'(power_state), 36'h2);
    host_u.pins(1'b0, 1'b0);
    host_u.idle(25);
    chk("wake", 36'(power_state), 36'h0);
    chk("left", 36'(exp_q.size()), 36'h0);
    chk("drop", 36'(write_dropped), 36'h0);
    chk("room", 36'(write_ready), 36'h1);
    $display("test drive and sleep done");
    wrap_up();
  end
  function automatic logic [35:0] mrg(logic [35:0] o, logic [35:0] n,
                                      logic [3:0] l);
    for (int g = 0; g < 4; g++) if (!l[g]) o[9*g +: 9] = n[9*g +: 9];
    return o;
  endfunction : mrg
endmodule : test_burst_sram_sync_control
bind burst_sram_sync_control burst_sram_props chk_u (.clk, .rst,
  .chip_enable_n, .select_active_high, .select_active_low,
  .proc_addr_strobe, .cache_addr_strobe, .global_write_n,
  .byte_write_gate, .output_drive_n, .sleep_request, .data_oe,
  .power_state, .write_ready, .write_dropped);
